// ### design/cstif_core.sv
// top of the character store and instruction format unit
// assumes: APB master on the register side; core storage that samples
// mem_re_out/mem_we_out at a rising edge and presents read data in the
// cycle after the one in which mem_re_out was high
//
// What this block does
// RULE1: add check bit to make stored parity odd
// RULE2: check bit hidden, only six bits used
// RULE3: bit positions count from the right, zero
// RULE4: zone is bits 5-4, numeric 3-0
// RULE5: negative when lsb character bit five set
// RULE6: operand time grows with field length
// RULE7: fetch five consecutive characters as 30 bits
// RULE8: counter points at msb character, adds five
// RULE9: redirect loads target instead of adding five
// RULE10: opcode from bits 29 to 25
// RULE11: index from bits 24-22, bit 21 ignored
// RULE12: operand address from bits 20 to 6
// RULE13: modifier from bits 5 to 0
// RULE14: 4096-character modules, two to eight
// RULE15: contiguous addresses from zero to size-1
// RULE16: character addresses are 15 bits
// RULE17: read beyond storage flags parity error
// RULE18: write beyond storage is suppressed
// RULE19: low 256 positions form 64 tetrads
// RULE20: index registers in tetrads nine to fifteen
// RULE21: first fetched character gives bits 29-24
//
// The register addresses and the APB register port were chosen for this implementation.
module cstif_core
  import cstif_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                reset_n_in,
  input  wire logic                clk_en_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [PADDR_W-1:0]  paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  output logic      [ADDR_W-1:0]   mem_addr_out,
  output logic      [STORED_W-1:0] mem_wdata_out,
  output logic                     mem_we_out,
  output logic                     mem_re_out,
  input  wire logic [STORED_W-1:0] mem_rdata_in,
  output logic                     busy_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_INDEX, ST_OPERAND, ST_FINISH, ST_CHAR_RD
  } cstif_state_t;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  cstif_state_t        state_reg, state_next;
  logic [1:0]          phase_reg;
  logic [LEN_W-1:0]    step_reg;
  logic                oor_reg;
  logic [ADDR_W-1:0]   instruction_sequence_counter_reg;
  logic [ADDR_W-1:0]   target_reg;
  logic                redirect_reg;
  logic [MOD_W-1:0]    modules_reg;
  logic [LEN_W-1:0]    len_reg;
  logic [INSTR_W-1:0]  instr_reg;
  logic [23:0]         index_acc_reg;
  logic [ADDR_W-1:0]   eff_reg;
  logic [ADDR_W-1:0]   char_addr_reg;
  logic [CHAR_W-1:0]   char_wdata_reg;
  logic [CHAR_W-1:0]   char_rdata_reg;
  logic                parity_err_reg;
  logic                suppressed_reg;
  logic                negative_reg;
  logic [1:0]          zone_reg;
  logic [3:0]          numeric_reg;
  logic [ADDR_W-1:0]   mem_addr_reg;
  logic [STORED_W-1:0] mem_wdata_reg;
  logic                mem_we_reg;
  logic                mem_re_reg;

  cstif_char_if ch ();

  cstif_char_unit u_char (
    .ch (ch.unit)
  );

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire bus_acc   = psel_in & penable_in & clk_en_in;
  wire bus_wr    = bus_acc & pwrite_in;
  wire wr_ctrl   = bus_wr & (paddr_in == OFS_CTRL);
  wire wr_cfg    = bus_wr & (paddr_in == OFS_CFG);
  wire wr_target = bus_wr & (paddr_in == OFS_TARGET);
  wire wr_cnt    = bus_wr & (paddr_in == OFS_COUNTER);
  wire wr_status = bus_wr & (paddr_in == OFS_STATUS);
  wire wr_caddr  = bus_wr & (paddr_in == OFS_CADDR);
  wire wr_cdata  = bus_wr & (paddr_in == OFS_CDATA);
  wire idle      = (state_reg == ST_IDLE);
  wire go_start  = wr_ctrl & pwdata_in[CTRL_START] & idle;
  wire go_cwr    = wr_ctrl & pwdata_in[CTRL_CWR] & idle & ~go_start;
  wire go_crd    = wr_ctrl & pwdata_in[CTRL_CRD] & idle & ~go_start
                   & ~pwdata_in[CTRL_CWR];
  wire [MOD_W-1:0] cfg_mod = pwdata_in[MOD_W-1:0];
  wire [LEN_W-1:0] cfg_len = pwdata_in[8+LEN_W-1:8];

  // ------------------------------------------------------------------
  // instruction fields, bit zero is the rightmost
  // ------------------------------------------------------------------
  wire [4:0]        f_op  = instr_reg[OP_HI:OP_LO];     // RULE10 RULE3
  wire [2:0]        f_idx = instr_reg[IDX_HI:IDX_LO];   // RULE11
  wire [ADDR_W-1:0] f_m   = instr_reg[M_HI:M_LO];       // RULE12
  wire [CHAR_W-1:0] f_c   = instr_reg[C_HI:C_LO];       // RULE13

  // ------------------------------------------------------------------
  // storage addressing
  // ------------------------------------------------------------------
  wire [CHAR_W-1:0] rd_ch = oor_reg ? 6'h00 : ch.rd_char;
  wire [INSTR_W-1:0] instr_shift = {instr_reg[INSTR_W-7:0], rd_ch}; // RULE21
  wire [23:0] acc_shift = {index_acc_reg[17:0], rd_ch};
  wire [2:0]  new_idx   = instr_shift[IDX_HI:IDX_LO]; // RULE11
  wire [5:0]  tetrad    = {INDEX_TETRAD_HI, f_idx};   // RULE20
  // tetrad n covers positions 4n..4n+3 of the lowest 256
  wire [ADDR_W-1:0] tetrad_base = {7'h00, tetrad, 2'h0}; // RULE19
  wire [ADDR_W-1:0] step_ext = {9'h000, step_reg};
  wire [ADDR_W-1:0] fetch_addr = instruction_sequence_counter_reg
                                 + step_ext; // RULE7
  wire [ADDR_W-1:0] index_addr = tetrad_base + step_ext;
  wire [ADDR_W-1:0] oper_addr  = eff_reg - step_ext; // RULE6
  wire [ADDR_W-1:0] idx_sum    = instr_reg[M_HI:M_LO]
                                 + acc_shift[ADDR_W-1:0]; // RULE20
  // installed size is modules * 4096, one contiguous range
  wire [ADDR_W:0] limit = {modules_reg, 12'h000};  // RULE14 RULE15
  wire [ADDR_W-1:0] rd_addr =
      (state_reg == ST_FETCH)   ? fetch_addr :
      (state_reg == ST_INDEX)   ? index_addr :
      (state_reg == ST_OPERAND) ? oper_addr  : char_addr_reg;
  wire rd_oor = ({1'b0, rd_addr} >= limit);          // RULE15 RULE16
  wire wr_oor = ({1'b0, char_addr_reg} >= limit);    // RULE18
  wire reading = (state_reg == ST_FETCH) | (state_reg == ST_INDEX)
                 | (state_reg == ST_OPERAND) | (state_reg == ST_CHAR_RD);
  wire issue   = reading & (phase_reg == 2'h0);
  wire cap     = reading & (phase_reg == 2'h2);
  wire cap_err = cap & (oor_reg | ~ch.rd_par_ok);    // RULE17
  wire [LEN_W-1:0] oper_last = len_reg - 6'h01;
  wire fetch_done = cap & (state_reg == ST_FETCH)
                    & (step_reg[2:0] == INSTR_LAST);
  wire index_done = cap & (state_reg == ST_INDEX)
                    & (step_reg[1:0] == TETRAD_LAST);
  wire oper_done  = cap & (state_reg == ST_OPERAND)
                    & (step_reg == oper_last);

  assign ch.wr_char   = char_wdata_reg;
  assign ch.rd_stored = mem_rdata_in;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  // one character per three cycles: issue, storage access, capture
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (go_start) begin
          state_next = ST_FETCH;
        end else if (go_crd) begin
          state_next = ST_CHAR_RD;
        end
      end
      ST_FETCH: begin
        if (fetch_done) begin
          state_next = (new_idx != 3'h0) ? ST_INDEX : ST_OPERAND; // RULE11
        end
      end
      ST_INDEX: begin
        if (index_done) begin
          state_next = ST_OPERAND;
        end
      end
      ST_OPERAND: begin
        if (oper_done) begin
          state_next = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_next = ST_IDLE;
      end
      ST_CHAR_RD: begin
        if (cap) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // sequencer registers
  // ------------------------------------------------------------------
  // phase and step walk the characters of the current state
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_IDLE;
      phase_reg <= 2'h0;
      step_reg  <= 6'h00;
      oor_reg   <= 1'b0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        phase_reg <= 2'h0;
        step_reg  <= 6'h00;
      end else if (reading) begin
        phase_reg <= cap ? 2'h0 : phase_reg + 2'h1;
        step_reg  <= cap ? step_reg + 6'h01 : step_reg;
      end
      if (issue) begin
        oor_reg <= rd_oor; // RULE17
      end
    end
  end

  // ------------------------------------------------------------------
  // storage port
  // ------------------------------------------------------------------
  // reads beyond storage never reach the modules; writes there drop
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mem_addr_reg  <= 15'h0000;
      mem_wdata_reg <= 7'h00;
      mem_we_reg    <= 1'b0;
      mem_re_reg    <= 1'b0;
    end else if (clk_en_in) begin
      mem_re_reg <= issue & ~rd_oor;            // RULE17
      mem_we_reg <= go_cwr & ~wr_oor;           // RULE18
      if (issue) begin
        mem_addr_reg <= rd_addr;
      end else if (go_cwr) begin
        mem_addr_reg  <= char_addr_reg;
        mem_wdata_reg <= ch.wr_stored;          // RULE1
      end
    end
  end

  // ------------------------------------------------------------------
  // instruction assembly, index and operand
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      instr_reg     <= 30'h00000000;
      index_acc_reg <= 24'h000000;
      eff_reg       <= 15'h0000;
      negative_reg  <= 1'b0;
      zone_reg      <= 2'h0;
      numeric_reg   <= 4'h0;
    end else if (clk_en_in) begin
      if (cap & (state_reg == ST_FETCH)) begin
        instr_reg <= instr_shift; // RULE7 RULE21
      end
      if (fetch_done) begin
        eff_reg <= instr_shift[M_HI:M_LO]; // RULE12
      end
      if (cap & (state_reg == ST_INDEX)) begin
        index_acc_reg <= acc_shift;
      end
      if (index_done) begin
        eff_reg <= idx_sum; // RULE20
      end
      // least significant character comes first and gives the sign
      if (cap & (state_reg == ST_OPERAND) & (step_reg == 6'h00)) begin
        negative_reg <= ~oor_reg & ch.rd_negative; // RULE5
        zone_reg     <= oor_reg ? 2'h0 : ch.rd_zone;    // RULE4
        numeric_reg  <= oor_reg ? 4'h0 : ch.rd_numeric; // RULE4
      end
    end
  end

  // ------------------------------------------------------------------
  // instruction counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      instruction_sequence_counter_reg <= 15'h0000;
      redirect_reg <= 1'b0;
      target_reg   <= 15'h0000;
    end else if (clk_en_in) begin
      if (wr_target) begin
        target_reg <= pwdata_in[ADDR_W-1:0];
      end
      if (state_reg == ST_FINISH) begin
        instruction_sequence_counter_reg <= redirect_reg ? target_reg
            : instruction_sequence_counter_reg + INSTR_STEP; // RULE8 RULE9
        redirect_reg <= 1'b0;
      end else begin
        if (wr_cnt & idle) begin
          instruction_sequence_counter_reg <= pwdata_in[ADDR_W-1:0];
        end
        if (wr_ctrl & pwdata_in[CTRL_REDIR]) begin
          redirect_reg <= 1'b1; // RULE9
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // configuration, character access and sticky status
  // ------------------------------------------------------------------
  // module count is held within two to eight; hardware set beats clear
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      modules_reg    <= MIN_MODULES;
      len_reg        <= RST_LEN;
      char_addr_reg  <= 15'h0000;
      char_wdata_reg <= 6'h00;
      char_rdata_reg <= 6'h00;
      parity_err_reg <= 1'b0;
      suppressed_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_cfg & idle) begin
        modules_reg <= (cfg_mod < MIN_MODULES) ? MIN_MODULES :
                       (cfg_mod > MAX_MODULES) ? MAX_MODULES : cfg_mod;
        len_reg     <= (cfg_len == 6'h00) ? RST_LEN : cfg_len;
      end
      if (wr_caddr & idle) begin
        char_addr_reg <= pwdata_in[ADDR_W-1:0];
      end
      if (wr_cdata & idle) begin
        char_wdata_reg <= pwdata_in[CHAR_W-1:0]; // RULE2
      end
      if (cap & (state_reg == ST_CHAR_RD)) begin
        char_rdata_reg <= rd_ch; // RULE2
      end
      parity_err_reg <= cap_err | (parity_err_reg
                        & ~(wr_status & pwdata_in[STAT_PERR])); // RULE17
      suppressed_reg <= (go_cwr & wr_oor) | (suppressed_reg
                        & ~(wr_status & pwdata_in[STAT_SUPP])); // RULE18
    end
  end

  // ------------------------------------------------------------------
  // read data and outputs
  // ------------------------------------------------------------------
  wire [31:0] rd_ctrl   = {31'h00000000, redirect_reg} << CTRL_REDIR;
  wire [31:0] rd_cfg    = {18'h00000, len_reg, 4'h0, modules_reg};
  wire [31:0] rd_decode = {10'h000, f_c, 5'h00, f_idx, 3'h0, f_op};
  wire [31:0] rd_addrs  = {1'b0, eff_reg, 1'b0, f_m};
  wire [31:0] rd_status = {16'h0000, numeric_reg, 2'h0, zone_reg,
                           4'h0, suppressed_reg, negative_reg,
                           parity_err_reg, ~idle};
  wire hit = (paddr_in == OFS_CTRL)   | (paddr_in == OFS_CFG)
           | (paddr_in == OFS_TARGET) | (paddr_in == OFS_COUNTER)
           | (paddr_in == OFS_INSTR)  | (paddr_in == OFS_DECODE)
           | (paddr_in == OFS_ADDR)   | (paddr_in == OFS_STATUS)
           | (paddr_in == OFS_CADDR)  | (paddr_in == OFS_CDATA);
  wire [31:0] rd_mux =
      (paddr_in == OFS_CTRL)    ? rd_ctrl :
      (paddr_in == OFS_CFG)     ? rd_cfg :
      (paddr_in == OFS_TARGET)  ? {17'h00000, target_reg} :
      (paddr_in == OFS_COUNTER) ?
          {17'h00000, instruction_sequence_counter_reg} :
      (paddr_in == OFS_INSTR)   ? {2'h0, instr_reg} :
      (paddr_in == OFS_DECODE)  ? rd_decode :
      (paddr_in == OFS_ADDR)    ? rd_addrs :
      (paddr_in == OFS_STATUS)  ? rd_status :
      (paddr_in == OFS_CADDR)   ? {17'h00000, char_addr_reg} :
      (paddr_in == OFS_CDATA)   ? {26'h0000000, char_rdata_reg} :
                                  32'h00000000;

  assign prdata_out    = (psel_in & ~pwrite_in) ? rd_mux : 32'h00000000;
  assign pready_out    = clk_en_in;
  assign pslverr_out   = psel_in & penable_in & ~hit;
  assign mem_addr_out  = mem_addr_reg;
  assign mem_wdata_out = mem_wdata_reg;
  assign mem_we_out    = mem_we_reg;
  assign mem_re_out    = mem_re_reg;
  assign busy_out      = ~idle;

endmodule : cstif_core

// ### design/cstif_pkg.sv
// package of constants for the character store and instruction format unit
// assumes: one clock, APB register access, core storage behind plain ports
package cstif_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int ADDR_W      = 15;
  localparam int CHAR_W      = 6;
  localparam int STORED_W    = 7;
  localparam int INSTR_W     = 30;
  localparam int LEN_W       = 6;
  localparam int MOD_W       = 4;
  localparam int PADDR_W     = 8;

  // ------------------------------------------------------------------
  // storage geometry
  // ------------------------------------------------------------------
  localparam int MODULE_CHARS = 4096;
  localparam logic [MOD_W-1:0] MIN_MODULES = 4'h2;
  localparam logic [MOD_W-1:0] MAX_MODULES = 4'h8;
  localparam logic [2:0] INSTR_LAST  = 3'h4;   // five characters, 0..4
  localparam logic [1:0] TETRAD_LAST = 2'h3;   // four characters, 0..3
  localparam logic [2:0] INDEX_TETRAD_HI = 3'h1; // tetrads 9..15 = 001xxx
  localparam logic [ADDR_W-1:0] INSTR_STEP = 15'h0005;

  // ------------------------------------------------------------------
  // instruction fields
  // ------------------------------------------------------------------
  localparam int OP_HI  = 29;
  localparam int OP_LO  = 25;
  localparam int IDX_HI = 24;
  localparam int IDX_LO = 22;
  localparam int M_HI   = 20;
  localparam int M_LO   = 6;
  localparam int C_HI   = 5;
  localparam int C_LO   = 0;

  // ------------------------------------------------------------------
  // character fields
  // ------------------------------------------------------------------
  localparam int ZONE_HI = 5;
  localparam int ZONE_LO = 4;
  localparam int NUM_HI  = 3;
  localparam int NUM_LO  = 0;
  localparam int SIGN_BIT = 5;

  // ------------------------------------------------------------------
  // register offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [PADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [PADDR_W-1:0] OFS_CFG     = 8'h04;
  localparam logic [PADDR_W-1:0] OFS_TARGET  = 8'h08;
  localparam logic [PADDR_W-1:0] OFS_COUNTER = 8'h0C;
  localparam logic [PADDR_W-1:0] OFS_INSTR   = 8'h10;
  localparam logic [PADDR_W-1:0] OFS_DECODE  = 8'h14;
  localparam logic [PADDR_W-1:0] OFS_ADDR    = 8'h18;
  localparam logic [PADDR_W-1:0] OFS_STATUS  = 8'h1C;
  localparam logic [PADDR_W-1:0] OFS_CADDR   = 8'h20;
  localparam logic [PADDR_W-1:0] OFS_CDATA   = 8'h24;
  localparam int CTRL_START = 0;
  localparam int CTRL_REDIR = 1;
  localparam int CTRL_CWR   = 2;
  localparam int CTRL_CRD   = 3;
  localparam int STAT_PERR  = 1;
  localparam int STAT_SUPP  = 3;
  localparam logic [LEN_W-1:0] RST_LEN = 6'h01;

endpackage : cstif_pkg

// ### design/cstif_char_if.sv
// interface between the controller and its character unit
// assumes: purely combinational exchange inside one clock domain
interface cstif_char_if;
  import cstif_pkg::*;
  logic [CHAR_W-1:0]   wr_char;
  logic [STORED_W-1:0] wr_stored;
  logic [STORED_W-1:0] rd_stored;
  logic [CHAR_W-1:0]   rd_char;
  logic                rd_par_ok;
  logic [1:0]          rd_zone;
  logic [3:0]          rd_numeric;
  logic                rd_negative;

  modport unit (input  wr_char, rd_stored,
                output wr_stored, rd_char, rd_par_ok, rd_zone,
                       rd_numeric, rd_negative);
  modport user (output wr_char, rd_stored,
                input  wr_stored, rd_char, rd_par_ok, rd_zone,
                       rd_numeric, rd_negative);
endinterface : cstif_char_if

// ### design/cstif_char_unit.sv
// character unit: check bit generation and check, zone/numeric split
// assumes: stored characters carry the check bit in bit 6
module cstif_char_unit
  import cstif_pkg::*;
(
  cstif_char_if.unit ch
);

  // ------------------------------------------------------------------
  // write side
  // ------------------------------------------------------------------
  // even count of ones gets a check bit so the stored word is odd
  assign ch.wr_stored = {~(^ch.wr_char), ch.wr_char}; // RULE1

  // ------------------------------------------------------------------
  // read side
  // ------------------------------------------------------------------
  // programs only see the six data bits
  assign ch.rd_char     = ch.rd_stored[CHAR_W-1:0]; // RULE2
  assign ch.rd_par_ok   = ^ch.rd_stored;            // RULE1
  // zone and numeric parts, sign in bit five
  assign ch.rd_zone     = ch.rd_stored[ZONE_HI:ZONE_LO]; // RULE4
  assign ch.rd_numeric  = ch.rd_stored[NUM_HI:NUM_LO];   // RULE4
  assign ch.rd_negative = ch.rd_stored[SIGN_BIT];        // RULE5

endmodule : cstif_char_unit

// ### test/cstif_store_model.sv
// storage model: an array of seven-bit stored characters
// assumes: read data is wanted only in the cycle after the read pulse
module cstif_store_model (
  input  wire logic [14:0] addr_in,
  input  wire logic        clk_in,
  input  wire logic [6:0]  wdata_in,
  input  wire logic        we_in,
  input  wire logic        re_in,
  output logic      [6:0]  rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] mem [0:32767];
  logic [6:0] rd_reg;
  logic       rd_valid_reg;
  // writes land and reads launch at the rising edge
  always @(posedge clk_in) begin
    if (we_in) mem[addr_in] <= wdata_in;
    rd_valid_reg <= re_in;
    if (re_in) rd_reg <= mem[addr_in];
  end
  // outside the answer cycle the lines carry garbage, not the last value
  assign rdata_out = rd_valid_reg ? rd_reg : ~rd_reg;
endmodule : cstif_store_model

// ### test/cstif_core_sva.sv
// checker for the character store unit, bound onto its top module
// assumes: one clock domain, synchronous active low reset
module cstif_core_sva
  import cstif_pkg::*;
(
  input wire logic                clk_in,
  input wire logic                reset_n_in,
  input wire logic                clk_en_in,
  input wire logic                psel_in,
  input wire logic                penable_in,
  input wire logic                pwrite_in,
  input wire logic [PADDR_W-1:0]  paddr_in,
  input wire logic [31:0]         prdata_out,
  input wire logic                pready_out,
  input wire logic [ADDR_W-1:0]   mem_addr_out,
  input wire logic [STORED_W-1:0] mem_wdata_out,
  input wire logic                mem_we_out,
  input wire logic                mem_re_out,
  input wire logic                busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // read access phase seen on the bus
  wire rd_acc = psel_in && penable_in && !pwrite_in;
  // a read pulse followed by an enabled cycle
  sequence s_run_re;
    mem_re_out && clk_en_in ##1 clk_en_in;
  endsequence
  a_we_odd_par: assert property (
    mem_we_out |-> ^mem_wdata_out) else $error("even parity stored");
  a_we_single: assert property (
    mem_we_out && clk_en_in |=> !mem_we_out) else $error("long write");
  a_re_spacing: assert property (
    s_run_re |-> !mem_re_out ##1 !mem_re_out) else $error("reads too close");
  a_busy_bound: assert property (
    $rose(busy_out) |-> ##[1:300] !busy_out) else $error("busy hangs");
  a_freeze_state: assert property (
    !clk_en_in |=> $stable(busy_out) && $stable(mem_addr_out))
    else $error("state moved while frozen");
  a_ready_follow: assert property (
    pready_out == clk_en_in) else $error("ready not tied to enable");
  a_cdata_six: assert property (
    rd_acc && paddr_in == OFS_CDATA |-> prdata_out[31:6] == 26'h0)
    else $error("check bit visible");
  a_decode_gaps: assert property (
    rd_acc && paddr_in == OFS_DECODE |-> prdata_out[7:5] == 3'h0 &&
    prdata_out[15:11] == 5'h0 && prdata_out[31:22] == 10'h0)
    else $error("decode gaps not zero");
endmodule : cstif_core_sva

bind cstif_core cstif_core_sva u_cstif_core_sva (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .busy_out(busy_out),
  .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
  .mem_we_out(mem_we_out), .mem_re_out(mem_re_out));

// ### test/cstif_core_tb.sv
// self-checking bench for the character store unit
// assumes: storage model stands on the memory ports
module cstif_core_tb
  import cstif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 0, reset_n_in = 0, clk_en_in = 1, psel_in = 0;
  logic        penable_in = 0, pwrite_in = 0, pready_out, pslverr_out;
  logic        mem_we_out, mem_re_out, busy_out, err;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [14:0] mem_addr_out;
  logic [6:0]  mem_wdata_out, mem_rdata_in;
  int          miscompares = 0, comparisons = 0;
  always #20 clk_in = ~clk_in;
  cstif_core u_cstif_core (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out),
    .mem_re_out(mem_re_out), .mem_rdata_in(mem_rdata_in),
    .busy_out(busy_out));
  cstif_store_model u_cstif_store_model (.clk_in(clk_in),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .we_in(mem_we_out),
    .re_in(mem_re_out), .rdata_out(mem_rdata_in));
  // one bus transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do @(posedge clk_in); while (pready_out !== 1'h1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic idle;
    repeat (2) @(posedge clk_in);
    while (busy_out !== 1'h0) @(posedge clk_in);
    @(posedge clk_in);
  endtask : idle
  // stored form of a character with its check bit
  function automatic logic [6:0] sw(input logic [5:0] c);
    return {~^c, c};
  endfunction : sw
  task automatic close_out;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // main sequence: reset, character traffic, range limits, instructions
  initial begin
    logic [5:0]  c;
    logic [14:0] a, m, v, e, cc, t;
    logic [29:0] ins;
    void'($urandom(32'h5168821E));
    u_cstif_store_model.mem[15'h2000] = 7'h7F;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'h1;
    rdc(OFS_CFG, 32'h0000_0102);
    rdc(OFS_COUNTER, 32'h0);
    rdc(8'hFC, 32'h0);
    chk(32'(err), 32'h1);
    for (int k = 0; k < 6; k++) begin
      a = (k == 5) ? 15'h2000 : 15'($urandom_range(64, 8191));
      c = (k == 0) ? 6'h00 : 6'($urandom);
      apb(1'h1, OFS_CADDR, 32'(a));
      apb(1'h1, OFS_CDATA, 32'(c));
      apb(1'h1, OFS_CTRL, 32'h4);
      idle();
      chk(32'(u_cstif_store_model.mem[a]), (k == 5) ? 32'h7F : 32'(sw(c)));
      apb(1'h1, OFS_CTRL, 32'h8);
      idle();
      rdc(OFS_CDATA, (k == 5) ? 32'h0 : 32'(c));
      apb(1'h0, OFS_STATUS, 32'h0);
      chk(rd & 32'hA, (k == 5) ? 32'hA : 32'h0);
      apb(1'h1, OFS_CFG, (k == 5) ? 32'h10F : 32'h102);
    end
    rdc(OFS_CFG, 32'h0000_0108);
    apb(1'h1, OFS_STATUS, 32'hA);
    cc = 15'($urandom_range(100, 8000));
    apb(1'h1, OFS_COUNTER, 32'(cc));
    for (int k = 0; k < 3; k++) begin
      ins = 30'($urandom);
      ins[24:22] = 3'($urandom_range(0, 1));
      m = 15'($urandom_range(9000, 20000));
      ins[20:6] = m;
      v = 15'($urandom_range(0, 63));
      c = 6'($urandom);
      t = 15'($urandom);
      e = m + ((ins[24:22] == 3'h1) ? v : 15'h0);
      for (int j = 0; j < 5; j++) u_cstif_store_model.mem[cc + j] = sw(ins[29 - 6 * j -: 6]);
      for (int j = 36; j < 39; j++) u_cstif_store_model.mem[j] = sw(6'h00);
      u_cstif_store_model.mem[39] = sw(v[5:0]);
      u_cstif_store_model.mem[e] = sw(c);
      apb(1'h1, OFS_TARGET, 32'(t));
      apb(1'h1, OFS_CTRL, (k == 2) ? 32'h3 : 32'h1);
      clk_en_in <= 1'h0;
      repeat (3) @(posedge clk_in);
      clk_en_in <= 1'h1;
      idle();
      rdc(OFS_INSTR, 32'(ins));
      rdc(OFS_DECODE, {10'h0, ins[5:0], 5'h0, ins[24:22], 3'h0, ins[29:25]});
      rdc(OFS_ADDR, {1'h0, e, 1'h0, m});
      rdc(OFS_STATUS, {16'h0, c[3:0], 2'h0, c[5:4], 5'h0, c[5], 2'h0});
      cc = (k == 2) ? t : cc + INSTR_STEP;
      rdc(OFS_COUNTER, 32'(cc));
    end
    close_out();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    close_out();
  end
endmodule : cstif_core_tb
